/* File: rtl/sbm_host.sv */
`timescale 1ns/1ps
// bus master that drives the memory board over active-low bus pins
module sbm_host
   import sbm_pkg::*;
#(
   parameter int unsigned ADDR_W = 24,
   parameter int unsigned DATA_W = 16
) (
   input  wire logic                clock_i,
   input  wire logic                rstn_i,
   // user side
   input  wire logic                req_i,
   input  wire logic                req_write_i,
   input  wire logic [ADDR_W-1:0]   req_addr_i,
   input  wire logic [DATA_W-1:0]   req_wdata_i,
   input  wire logic                req_word_i,
   input  wire logic                pwr_down_i,
   output logic                     busy_o,
   output logic                     done_o,
   output logic                     timeout_o,
   output logic [DATA_W-1:0]        rdata_o,
   // bus side, all active low except dat_oe_o
   output logic [ADDR_W-1:0]        adr_n_o,
   output logic                     bhen_n_o,
   output logic                     mrdc_n_o,
   output logic                     mwtc_n_o,
   output logic                     init_n_o,
   output logic                     mpro_n_o,
   input  wire logic [DATA_W-1:0]   dat_n_i,
   output logic [DATA_W-1:0]        dat_n_o,
   output logic                     dat_oe_o,
   input  wire logic                xack_n_i
);
   // -------------------------------------------------------------
   // helpers
   // -------------------------------------------------------------
   // true once a cycle counter has reached its limit
   function automatic logic reached(input logic [CNT_W-1:0] count,
                                    input int unsigned      limit);
      return (count >= CNT_W'(limit));
   endfunction

   // -------------------------------------------------------------
   // bus-side decode
   // -------------------------------------------------------------
   sbm_state_t             state;
   sbm_state_t             next_state;
   logic [CNT_W-1:0]       cnt;
   logic [12:0]            tmo;
   logic                   wr;
   logic [CNT_W-1:0]       pd_cnt;
   logic                   pd_cnt_done;
   // strobes derived from the state, the counters and the inputs
   wire logic              ack_seen  = ~xack_n_i;
   wire logic              setup_end = reached(cnt, ADDR_SETUP_CYC);
   wire logic              sep_end   = reached(cnt, CMD_SEP_CYC);
   wire logic              tmo_hit   = (tmo >= 13'(XACK_TMO_CYC));
   wire logic [DATA_W-1:0] rd_word   = ~dat_n_i;
   wire logic              take      = (state == SBM_IDLE) && req_i && init_n_o;
   wire logic              cmd_on    = (state == SBM_SETUP) && setup_end;
   wire logic              cmd_off   = (state == SBM_CMD) && (ack_seen || tmo_hit);
   wire logic              bus_free  = (state == SBM_RELEASE) && !ack_seen;
   wire logic              finish    = (state == SBM_SEP) && sep_end;
   wire logic              state_chg = (next_state != state);
   wire logic              no_ack    = tmo_hit && !ack_seen;

   // next state of the transfer sequence
   always_comb begin
      next_state = state;
      unique case (state)
         SBM_IDLE:    if (take) next_state = SBM_SETUP;
         SBM_SETUP:   if (cmd_on) next_state = SBM_CMD;
         SBM_CMD:     if (cmd_off) next_state = SBM_RELEASE;
         SBM_RELEASE: if (bus_free) next_state = SBM_SEP;
         SBM_SEP:     if (finish) next_state = SBM_IDLE;
      endcase
   end

   // -------------------------------------------------------------
   // sequencer
   // -------------------------------------------------------------
   // state register
   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         state <= SBM_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // cycle counter, restarted on every change of state
   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         cnt <= '0;
      end else begin
         cnt <= state_chg ? '0 : cnt + CNT_W'(1);
      end
   end

   // acknowledge wait counter, runs only while a command is out
   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         tmo <= '0;
      end else begin
         tmo <= (state == SBM_CMD) ? tmo + 13'(1) : '0;
      end
   end

   // -------------------------------------------------------------
   // bus pins
   // -------------------------------------------------------------
   // address, byte enable and write data, held until the acknowledge is gone
   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         adr_n_o  <= '1;
         bhen_n_o <= 1'b1;
         wr       <= 1'b0;
         dat_n_o  <= '1;
      end else if (take) begin
         adr_n_o  <= ~req_addr_i;
         bhen_n_o <= ~(req_word_i | req_addr_i[0]);
         wr       <= req_write_i;
         dat_n_o  <= ~req_wdata_i;
      end else if (bus_free) begin
         adr_n_o  <= '1;
         bhen_n_o <= 1'b1;
      end
   end

   // data drivers on for writes only
   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         dat_oe_o <= 1'b0;
      end else if (take) begin
         dat_oe_o <= req_write_i;
      end else if (bus_free) begin
         dat_oe_o <= 1'b0;
      end
   end

   // command strobes; read data is taken before the strobe rises
   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         mrdc_n_o <= 1'b1;
         mwtc_n_o <= 1'b1;
      end else if (cmd_on) begin
         mrdc_n_o <= wr;
         mwtc_n_o <= ~wr;
      end else if (cmd_off) begin
         mrdc_n_o <= 1'b1;
         mwtc_n_o <= 1'b1;
      end
   end

   // -------------------------------------------------------------
   // user status
   // -------------------------------------------------------------
   // busy from accept to done, done for one cycle
   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         busy_o <= 1'b0;
         done_o <= 1'b0;
      end else begin
         done_o <= finish;
         if (take) begin
            busy_o <= 1'b1;
         end else if (finish) begin
            busy_o <= 1'b0;
         end
      end
   end

   // timeout flag, cleared on the next accept
   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         timeout_o <= 1'b0;
      end else if (take) begin
         timeout_o <= 1'b0;
      end else if (cmd_off) begin
         timeout_o <= no_ack;
      end
   end

   // read data kept until the next read completes
   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         rdata_o <= '0;
      end else if (cmd_off && !wr) begin
         rdata_o <= rd_word;
      end
   end

   // -------------------------------------------------------------
   // power-down sequencing
   // -------------------------------------------------------------
   // initialise first, memory protect only after the lead time
   assign pd_cnt_done = reached(pd_cnt, INIT_TO_MPRO_CYC);
   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         init_n_o <= 1'b1;
         mpro_n_o <= 1'b1;
      end else if (pwr_down_i) begin
         init_n_o <= 1'b0;
         if (pd_cnt_done) mpro_n_o <= 1'b0;
      end else begin
         // both lines let go together when power returns
         init_n_o <= 1'b1;
         mpro_n_o <= 1'b1;
      end
   end

   // lead-time counter, starts once initialise is out
   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         pd_cnt <= '0;
      end else if (pwr_down_i && !init_n_o && !pd_cnt_done) begin
         pd_cnt <= pd_cnt + CNT_W'(1);
      end else if (!pwr_down_i) begin
         pd_cnt <= '0;
      end
   end
endmodule

/* File: rtl/sbm_pkg.sv */
package sbm_pkg;
   localparam int unsigned CLK_PERIOD_NS   = 50;
   // bus timing minima in ns, and the acknowledge maximum
   localparam int unsigned ADDR_SETUP_NS   = 50;
   localparam int unsigned CMD_SEP_NS      = 100;
   localparam int unsigned INIT_TO_MPRO_NS = 100;
   localparam int unsigned XACK_MAX_NS     = 8000;
   // least times round up, longest time rounds down
   localparam int unsigned ADDR_SETUP_CYC  = (ADDR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned CMD_SEP_CYC     = (CMD_SEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned INIT_TO_MPRO_CYC =
      (INIT_TO_MPRO_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned XACK_TMO_CYC    = XACK_MAX_NS / CLK_PERIOD_NS;
   localparam int unsigned CNT_W           = 8;
   typedef enum logic [2:0] {
      SBM_IDLE,
      SBM_SETUP,
      SBM_CMD,
      SBM_RELEASE,
      SBM_SEP
   } sbm_state_t;
endpackage

/* File: testbench/sbm_board.sv */
`timescale 1ns/1ps
module sbm_board #(
   parameter int DLY = 3
) (
   input  logic        clock_i,
   input  logic        bhen_n_i,
   input  logic        mrdc_n_i,
   input  logic        mwtc_n_i,
   input  logic        init_n_i,
   input  logic        mpro_n_i,
   input  logic        inh1_n_i,
   input  logic        inh2_n_i,
   input  logic [23:0] adr_n_i,
   input  logic [15:0] dat_n_i,
   output logic [15:0] dat_n_o,
   output logic        xack_n_o,
   output logic        inh1_n_o
);
   logic [15:0] mem [16];
   logic [3:0]  cnt;
   wire         cmd = !(mrdc_n_i && mwtc_n_i);
   // the bank listens to inhibit 1 and inhibit 2
   wire         blk = !init_n_i || !mpro_n_i || !inh1_n_i || !inh2_n_i;
   // inhibit 1 generated for the lowest 64K unless inhibit 2 is received
   assign inh1_n_o = !(cmd && (~adr_n_i[23:16] == 8'h00) && inh2_n_i);
   // wait DLY cycles, move data, hold ack until the command drops; released lines pull high
   always @(posedge clock_i) begin
      if (blk || !cmd) begin
         {cnt, xack_n_o, dat_n_o} <= {4'h0, 17'h1FFFF};
      end else if (cnt < DLY) begin
         cnt <= cnt + 4'h1;
      end else begin
         xack_n_o <= 1'b0;
         if (!mrdc_n_i) dat_n_o <= ~mem[~adr_n_i[4:1]];
         if (!mwtc_n_i && adr_n_i[0]) mem[~adr_n_i[4:1]][7:0] <= ~dat_n_i[7:0];
         if (!mwtc_n_i && !bhen_n_i) mem[~adr_n_i[4:1]][15:8] <= ~dat_n_i[15:8];
      end
   end
endmodule

/* File: testbench/sbm_host_properties.sv */
`timescale 1ns/1ps
module sbm_host_properties (
   input logic        clock_i,
   input logic        rstn_i,
   input logic        mrdc_n_o,
   input logic        mwtc_n_o,
   input logic        init_n_o,
   input logic        mpro_n_o,
   input logic        dat_oe_o,
   input logic        xack_n_i,
   input logic        done_o,
   input logic        busy_o,
   input logic [23:0] adr_n_o
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rstn_i);
   // a command is out on the bus
   sequence s_cmd_out;
      !(mrdc_n_o & mwtc_n_o);
   endsequence
   // a command is out and already acknowledged
   sequence s_cmd_acked;
      !(mrdc_n_o & mwtc_n_o) && !xack_n_i;
   endsequence
   a_prot_late:
      assert property ($fell(mpro_n_o) |-> !$past(init_n_o, 1) && !$past(init_n_o, 2))
      else $error("protect without initialise lead");
   a_cmd_drop:
      assert property (s_cmd_acked |=> mrdc_n_o && mwtc_n_o) else $error("command held after ack");
   a_write_drive:
      assert property (!mwtc_n_o |-> dat_oe_o) else $error("no write data");
   a_adr_hold:
      assert property (s_cmd_out |-> $stable(adr_n_o)) else $error("address moved");
   a_init_under:
      assert property (!mpro_n_o |-> !init_n_o) else $error("protect without initialise");
   a_done_pulse:
      assert property (done_o |-> !busy_o ##1 !done_o) else $error("done not a single pulse");
endmodule
bind sbm_host sbm_host_properties u_sbm_host_properties (
   .clock_i  (clock_i),
   .rstn_i   (rstn_i),
   .mrdc_n_o (mrdc_n_o),
   .mwtc_n_o (mwtc_n_o),
   .init_n_o (init_n_o),
   .mpro_n_o (mpro_n_o),
   .dat_oe_o (dat_oe_o),
   .xack_n_i (xack_n_i),
   .done_o   (done_o),
   .busy_o   (busy_o),
   .adr_n_o  (adr_n_o)
);

/* File: testbench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
   logic        clock_i = 0, rstn_i = 0, req_i = 0, req_write_i = 0, req_word_i = 0;
   logic        pwr_down_i = 0, busy_o, done_o, timeout_o, bhen_n_o, mrdc_n_o, mwtc_n_o;
   logic        init_n_o, mpro_n_o, dat_oe_o, xack_n_i, inh1_n_o, inh1_seen;
   logic        inh1_n = 1, inh2_n = 1;
   logic [23:0] req_addr_i = 0, adr_n_o;
   logic [15:0] req_wdata_i = 0, rdata_o, dat_n_o, brd_n;
   int          n_fail = 0, comparisons = 0;
   wire  [15:0] dat_n_i = dat_oe_o ? dat_n_o : brd_n;
   always #25 clock_i = ~clock_i;
   sbm_host u_sbm_host (.clock_i(clock_i), .rstn_i(rstn_i), .req_i(req_i),
      .req_write_i(req_write_i), .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
      .req_word_i(req_word_i), .pwr_down_i(pwr_down_i), .busy_o(busy_o), .done_o(done_o),
      .timeout_o(timeout_o), .rdata_o(rdata_o), .adr_n_o(adr_n_o), .bhen_n_o(bhen_n_o),
      .mrdc_n_o(mrdc_n_o), .mwtc_n_o(mwtc_n_o), .init_n_o(init_n_o), .mpro_n_o(mpro_n_o),
      .dat_n_i(dat_n_i), .dat_n_o(dat_n_o), .dat_oe_o(dat_oe_o), .xack_n_i(xack_n_i));
   sbm_board u_sbm_board (.clock_i(clock_i), .bhen_n_i(bhen_n_o), .mrdc_n_i(mrdc_n_o),
      .mwtc_n_i(mwtc_n_o), .init_n_i(init_n_o), .mpro_n_i(mpro_n_o), .inh1_n_i(inh1_n),
      .inh2_n_i(inh2_n), .adr_n_i(adr_n_o), .dat_n_i(dat_n_i), .dat_n_o(brd_n),
      .xack_n_o(xack_n_i), .inh1_n_o(inh1_n_o));
   task automatic chk(input logic [16:0] g, e);
      comparisons++;
      n_fail += int'(g !== e);
      if (g !== e) $display("mismatch %0t got %h exp %h", $time, g, e);
   endtask
   task automatic xfer(input logic w, wd, input logic [23:0] a, input logic [15:0] d);
      {req_i, req_write_i, req_word_i, req_addr_i, req_wdata_i} <= {1'b1, w, wd, a, d};
      inh1_seen = 1'b0;
      @(posedge clock_i);
      req_i <= 1'b0;
      repeat (300) begin
         if (done_o !== 1'b1) begin
            @(posedge clock_i);
            if (inh1_n_o === 1'b0) inh1_seen = 1'b1;
         end
      end
   endtask
   // word write, even and odd byte writes back to back, then the merged word read back
   task automatic t_data();
      xfer(1'b1, 1'b1, 24'h10, 16'hA55A);
      xfer(1'b1, 1'b0, 24'h10, 16'h7E81);
      xfer(1'b1, 1'b0, 24'h11, 16'h3C00);
      xfer(1'b0, 1'b1, 24'h10, 16'h0000);
      chk({timeout_o, rdata_o}, 17'h03C81);
      chk({16'h0000, inh1_seen}, 17'h00001);
   endtask
   // inhibited board never acknowledges, so the host times out; then a clean read
   task automatic t_inhibit();
      inh1_n <= 1'b0;
      xfer(1'b0, 1'b1, 24'h10, 16'h0000);
      chk({timeout_o, 16'h0000}, 17'h10000);
      inh1_n <= 1'b1;
      inh2_n <= 1'b0;
      xfer(1'b0, 1'b1, 24'h10, 16'h0000);
      chk({timeout_o, 16'h0000}, 17'h10000);
      chk({16'h0000, inh1_seen}, 17'h00000);
      inh2_n <= 1'b1;
      xfer(1'b0, 1'b1, 24'h10, 16'h0000);
      chk({timeout_o, rdata_o}, 17'h03C81);
   endtask
   // power-down order, and a request refused while initialise is out
   task automatic t_pwr();
      pwr_down_i <= 1'b1;
      repeat (2) @(posedge clock_i);
      req_i <= 1'b1;
      repeat (3) @(posedge clock_i);
      chk({init_n_o, mpro_n_o, busy_o}, 17'h00000);
      req_i <= 1'b0;
   endtask
   task automatic end_of_test();
      $display("n_fail %0d comparisons %0d", n_fail, comparisons);
      if (n_fail == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge clock_i);
      rstn_i <= 1'b1;
      t_data();
      t_inhibit();
      t_pwr();
      end_of_test();
   end
   initial begin
      repeat (2000) @(posedge clock_i);
      n_fail++;
      end_of_test();
   end
endmodule
